// File: dclh_pkg.sv
package dclh_pkg;

	// Timing of the strobe clock and of the handshake.
	localparam int MCLK_NS        = 100;
	localparam int STROBE_HI_NS   = 400;
	localparam int STROBE_LO_NS   = 400;
	localparam int WORD2_SETUP_NS = 500;
	localparam int SYNC_STAGES    = 2;
	localparam logic [3:0] STROBE_HI_CYC  = 4'((STROBE_HI_NS + MCLK_NS - 1) / MCLK_NS);
	localparam logic [3:0] STROBE_LO_CYC  = 4'((STROBE_LO_NS + MCLK_NS - 1) / MCLK_NS);
	localparam logic [3:0] WORD2_WAIT_CYC =
		4'((WORD2_SETUP_NS + MCLK_NS - 1) / MCLK_NS + SYNC_STAGES);

	// Link word and sector geometry.
	localparam int         WORD_W       = 16;
	localparam int         FIFO_DEPTH   = 16;
	localparam logic [6:0] SECTOR_WORDS = 7'h5A;

	// First initiate word fields.
	localparam int W1_OP_LSB    = 0;
	localparam int W1_VAR_BIT   = 3;
	localparam int W1_UNIT_LSB  = 4;
	localparam int W1_SPARE_LSB = 8;
	localparam int W1_FA_LSB    = 11;
	// Second initiate word fields.
	localparam int W2_FA_LSB    = 0;

	// Operation codes that select the data direction.
	localparam logic [2:0] OP_READ  = 3'h1;
	localparam logic [2:0] OP_WRITE = 3'h2;

	// Check code generator; the polynomial value is arbitrary.
	localparam logic [31:0] FIRE_POLY = 32'h0000_0005;
	localparam logic [31:0] FIRE_INIT = 32'hFFFF_FFFF;

	// Result word flag positions; bits 15..3 carry drive status.
	localparam int RES_CHK_BIT  = 0;
	localparam int RES_PAR_BIT  = 1;
	localparam int RES_TERM_BIT = 2;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_W1    = 3'h1,
		ST_ACK1  = 3'h2,
		ST_W2    = 3'h3,
		ST_DATA  = 3'h4,
		ST_TERM  = 3'h5,
		ST_RES   = 3'h6
	} dclh_state_t;

	typedef enum logic [2:0] {
		PH_IDLE    = 3'h0,
		PH_INIT    = 3'h1,
		PH_DATA    = 3'h2,
		PH_SLIP    = 3'h3,
		PH_RESULT  = 3'h4,
		PH_WAITRES = 3'h5,
		PH_SEQERR  = 3'h6,
		PH_CTLTERM = 3'h7
	} dclh_phase_t;

endpackage

// File: dclh_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Driven words carry odd parity with parity line.
// - Ready after first word; drops only to terminate.
// - Busy after second word, held through result.
// - Select rise, busy/ready low: first word present.
// - After select falls, finish 180 characters, then result.
// - Execute low: slip, no transfers.
// - Strobe only runs while words move.
// - Phase decoded from select, busy, ready.
// - First word: op, variant, unit, spare, address.
// - Strobe leading edge precedes ready rising.
// - Second word: address bits 6-19, two spares.
// - Busy follows second word strobe; data mode.
// - Cannot proceed: drop ready, await select low.
// - Result word stable during its strobe, busy drops.
// - Read data stable for strobe width.
// - Controller terminates by dropping ready.
// - Select dropped: finish sector, then result.
// - One result descriptor per operation.
// - 32-bit check code per sector, error flagged on reads only.

module dclh_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic         mclk_i,
	input  wire logic         rstn_i,
	// Filling side.
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	// Draining side.
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_reg [DEPTH];
	logic [AW:0]  wptr_reg;
	logic [AW:0]  rptr_reg;

	assign in_ready_o  = (wptr_reg - rptr_reg) != (AW+1)'(DEPTH);
	assign out_valid_o = wptr_reg != rptr_reg;
	assign out_data_o  = mem_reg[rptr_reg[AW-1:0]];

	always_ff @(posedge mclk_i) begin
		if (in_valid_i && in_ready_o) begin
			mem_reg[wptr_reg[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			if (in_valid_i && in_ready_o) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (out_valid_o && out_ready_i) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
		end
	end
endmodule

module dclh_ctrl (
	// Clock and reset.
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	// Link from the control unit.
	input  wire logic [15:0] xw_i,
	input  wire logic        xpar_i,
	input  wire logic        send_i,
	input  wire logic        select_i,
	input  wire logic        execute_i,
	// Link toward the control unit.
	output logic [15:0]      xw_o,
	output logic             xpar_o,
	output logic             xw_oe_n_o,
	output logic             ready_o,
	output logic             busy_o,
	output logic             strobe_o,
	// Decoded command toward the drive side.
	output logic [2:0]       op_code_o,
	output logic             variant_o,
	output logic [3:0]       unit_o,
	output logic [2:0]       spare_o,
	output logic [18:0]      file_addr_o,
	output logic             cmd_valid_o,
	// Drive side control and status.
	input  wire logic        go_i,
	input  wire logic        term_i,
	input  wire logic [12:0] status_i,
	input  wire logic [31:0] fire_ref_i,
	output logic [2:0]       phase_o,
	output logic             seq_err_o,
	output logic [31:0]      fire_code_o,
	output logic             sector_done_o,
	// Read stream from the drive.
	input  wire logic [15:0] rd_data_i,
	input  wire logic        rd_valid_i,
	output logic             rd_ready_o,
	// Write stream to the drive.
	output logic [15:0]      wr_data_o,
	output logic             wr_valid_o,
	input  wire logic        wr_ready_i
);
	function automatic logic [31:0] fire_step(input logic [31:0] c, input logic [15:0] w);
		logic [31:0] r;
		r = c;
		for (int i = 15; i >= 0; i--) begin
			r = {r[30:0], 1'b0} ^ ((r[31] ^ w[i]) ? dclh_pkg::FIRE_POLY : 32'h0000_0000);
		end
		return r;
	endfunction

	function automatic logic [2:0] phase_of(input logic s, input logic b, input logic r,
		input logic e);
		logic [2:0] p;
		p = dclh_pkg::PH_INIT;
		case ({s, b, r})
			3'h0: p = dclh_pkg::PH_IDLE;
			3'h7: p = e ? dclh_pkg::PH_DATA : dclh_pkg::PH_SLIP;
			3'h2: p = dclh_pkg::PH_RESULT;
			3'h3: p = dclh_pkg::PH_WAITRES;
			3'h1: p = dclh_pkg::PH_SEQERR;
			3'h6: p = dclh_pkg::PH_CTLTERM;
			default: p = dclh_pkg::PH_INIT;
		endcase
		return p;
	endfunction

	dclh_pkg::dclh_state_t state_reg;
	logic [19:0] s1_reg;
	logic [19:0] s2_reg;
	logic [3:0]  cnt_reg;
	logic [6:0]  words_reg;
	logic        sel_d_reg;
	logic        dir_wr_reg;
	logic        go_reg;
	logic        term_req_reg;
	logic        sel_drop_reg;
	logic        chk_err_reg;
	logic        par_err_reg;
	logic        ctl_term_reg;
	logic [31:0] crc_reg;
	logic [15:0] xw_s;
	logic        par_s;
	logic        sel_s;
	logic        exec_s;
	logic        send_s;
	logic        pulse_end;
	logic        xfer_ok;
	logic        start_xfer;
	logic        push;
	logic        pop;
	logic [15:0] fout;
	logic        fout_valid;
	logic        fin_ready;

	assign {send_s, exec_s, sel_s, par_s, xw_s} = s2_reg;
	assign pulse_end  = cnt_reg == dclh_pkg::STROBE_HI_CYC + dclh_pkg::STROBE_LO_CYC - 4'h1;
	assign xfer_ok    = dir_wr_reg ? fin_ready : fout_valid;
	assign start_xfer = state_reg == dclh_pkg::ST_DATA && cnt_reg == 4'h0 && exec_s &&
		xfer_ok && !term_req_reg;
	assign push = dir_wr_reg ? start_xfer : rd_valid_i;
	assign pop  = dir_wr_reg ? wr_ready_i : (start_xfer && !dir_wr_reg);
	assign rd_ready_o = !dir_wr_reg && fin_ready;
	assign wr_valid_o = dir_wr_reg && fout_valid;
	assign wr_data_o  = fout;

	dclh_fifo #(.W(dclh_pkg::WORD_W), .DEPTH(dclh_pkg::FIFO_DEPTH)) u_fifo (
		.mclk_i      (mclk_i),
		.rstn_i      (rstn_i),
		.in_data_i   (dir_wr_reg ? xw_s : rd_data_i),
		.in_valid_i  (push),
		.in_ready_o  (fin_ready),
		.out_data_o  (fout),
		.out_valid_o (fout_valid),
		.out_ready_i (pop)
	);

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_reg    <= 20'h0_0000;
			s2_reg    <= 20'h0_0000;
			sel_d_reg <= 1'b0;
		end else begin
			s1_reg    <= {send_i, execute_i, select_i, xpar_i, xw_i};
			s2_reg    <= s1_reg;
			sel_d_reg <= sel_s;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase_o   <= dclh_pkg::PH_IDLE;
			seq_err_o <= 1'b0;
		end else begin
			phase_o   <= phase_of(sel_s, busy_o, ready_o, exec_s);
			seq_err_o <= ready_o && !busy_o && !sel_s;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			term_req_reg <= 1'b0;
		end else if (term_i) begin
			term_req_reg <= 1'b1;
		end else if (state_reg == dclh_pkg::ST_IDLE) begin
			term_req_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg     <= dclh_pkg::ST_IDLE;
			cnt_reg       <= 4'h0;
			words_reg     <= 7'h00;
			strobe_o      <= 1'b0;
			ready_o       <= 1'b0;
			busy_o        <= 1'b0;
			xw_o          <= 16'h0000;
			xpar_o        <= 1'b1;
			xw_oe_n_o     <= 1'b1;
			op_code_o     <= 3'h0;
			variant_o     <= 1'b0;
			unit_o        <= 4'h0;
			spare_o       <= 3'h0;
			file_addr_o   <= 19'h0_0000;
			cmd_valid_o   <= 1'b0;
			dir_wr_reg    <= 1'b0;
			go_reg        <= 1'b0;
			sel_drop_reg  <= 1'b0;
			chk_err_reg   <= 1'b0;
			par_err_reg   <= 1'b0;
			ctl_term_reg  <= 1'b0;
			crc_reg       <= dclh_pkg::FIRE_INIT;
			fire_code_o   <= 32'h0000_0000;
			sector_done_o <= 1'b0;
		end else begin
			cmd_valid_o   <= 1'b0;
			sector_done_o <= 1'b0;
			if (state_reg inside {dclh_pkg::ST_W1, dclh_pkg::ST_W2, dclh_pkg::ST_RES} ||
				(state_reg == dclh_pkg::ST_DATA && (cnt_reg != 4'h0 || start_xfer))) begin
				cnt_reg  <= pulse_end ? 4'h0 : cnt_reg + 4'h1;
				strobe_o <= cnt_reg < dclh_pkg::STROBE_HI_CYC && !pulse_end;
			end else if (state_reg == dclh_pkg::ST_ACK1) begin
				cnt_reg  <= cnt_reg + 4'h1;
				strobe_o <= 1'b0;
			end else begin
				cnt_reg  <= 4'h0;
				strobe_o <= 1'b0;
			end
			if (cnt_reg == 4'h0 && ^{xw_s, par_s} == 1'b0 && (state_reg inside
				{dclh_pkg::ST_W1, dclh_pkg::ST_W2} || (start_xfer && dir_wr_reg))) begin
				par_err_reg <= 1'b1;
			end
			case (state_reg)
				dclh_pkg::ST_IDLE: begin
					if (sel_s && !sel_d_reg && send_s && !busy_o && !ready_o) begin
						state_reg    <= dclh_pkg::ST_W1;
						par_err_reg  <= 1'b0;
						chk_err_reg  <= 1'b0;
						ctl_term_reg <= 1'b0;
						sel_drop_reg <= 1'b0;
						words_reg    <= 7'h00;
						crc_reg      <= dclh_pkg::FIRE_INIT;
					end
				end
				dclh_pkg::ST_W1: begin
					if (cnt_reg == 4'h0) begin
						op_code_o  <= xw_s[dclh_pkg::W1_OP_LSB +: 3];
						variant_o  <= xw_s[dclh_pkg::W1_VAR_BIT];
						unit_o     <= xw_s[dclh_pkg::W1_UNIT_LSB +: 4];
						spare_o    <= xw_s[dclh_pkg::W1_SPARE_LSB +: 3];
						file_addr_o[4:0] <= xw_s[dclh_pkg::W1_FA_LSB +: 5];
						dir_wr_reg <= xw_s[dclh_pkg::W1_OP_LSB +: 3] == dclh_pkg::OP_WRITE;
					end
					if (cnt_reg == dclh_pkg::STROBE_HI_CYC) begin
						ready_o <= 1'b1;
					end
					if (pulse_end) begin
						state_reg <= dclh_pkg::ST_ACK1;
					end
				end
				dclh_pkg::ST_ACK1: begin
					if (cnt_reg == dclh_pkg::WORD2_WAIT_CYC) begin
						state_reg <= dclh_pkg::ST_W2;
					end
				end
				dclh_pkg::ST_W2: begin
					if (cnt_reg == 4'h0) begin
						file_addr_o[18:5] <= xw_s[dclh_pkg::W2_FA_LSB +: 14];
						go_reg      <= go_i;
						cmd_valid_o <= 1'b1;
					end
					if (cnt_reg == dclh_pkg::STROBE_HI_CYC) begin
						busy_o <= 1'b1;
					end
					if (pulse_end) begin
						if (!go_reg) begin
							ready_o      <= 1'b0;
							ctl_term_reg <= 1'b1;
							state_reg    <= dclh_pkg::ST_TERM;
						end else begin
							state_reg <= dclh_pkg::ST_DATA;
						end
					end
				end
				dclh_pkg::ST_DATA: begin
					if (!sel_s) begin
						sel_drop_reg <= 1'b1;
					end
					if (cnt_reg == 4'h0 && term_req_reg) begin
						ready_o      <= 1'b0;
						ctl_term_reg <= 1'b1;
						xw_oe_n_o    <= 1'b1;
						state_reg    <= dclh_pkg::ST_TERM;
					end
					// read word held for the strobe
					if (start_xfer) begin
						crc_reg <= fire_step(crc_reg, dir_wr_reg ? xw_s : fout);
						if (!dir_wr_reg) begin
							xw_o      <= fout;
							xpar_o    <= ~^fout;
							xw_oe_n_o <= 1'b0;
						end
					end
					if (pulse_end) begin
						if (words_reg == dclh_pkg::SECTOR_WORDS - 7'h01) begin
							words_reg     <= 7'h00;
							sector_done_o <= 1'b1;
							crc_reg       <= dclh_pkg::FIRE_INIT;
							fire_code_o   <= crc_reg;
							if (!dir_wr_reg && crc_reg != fire_ref_i) begin
								chk_err_reg <= 1'b1;
							end
							if (sel_drop_reg || !sel_s) begin
								ready_o   <= 1'b0;
								xw_oe_n_o <= 1'b1;
								state_reg <= dclh_pkg::ST_TERM;
							end
						end else begin
							words_reg <= words_reg + 7'h01;
						end
					end
				end
				dclh_pkg::ST_TERM: begin
					if (!sel_s) begin
						xw_o      <= {status_i, ctl_term_reg, par_err_reg, chk_err_reg};
						xpar_o    <= ~^{status_i, ctl_term_reg, par_err_reg, chk_err_reg};
						xw_oe_n_o <= 1'b0;
						state_reg <= dclh_pkg::ST_RES;
					end
				end
				dclh_pkg::ST_RES: begin
					if (pulse_end) begin
						busy_o    <= 1'b0;
						xw_oe_n_o <= 1'b1;
						state_reg <= dclh_pkg::ST_IDLE;
					end
				end
				default: state_reg <= dclh_pkg::ST_IDLE;
			endcase
		end
	end

	sequence s_strobe_high;
		strobe_o [*4];
	endsequence

	a_ready_after_edge: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$rose(ready_o) |-> !busy_o && $past(strobe_o, 1))
		else $error("ready rose without a preceding strobe");
	a_odd_parity_out: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!xw_oe_n_o |-> ^{xw_o, xpar_o})
		else $error("driven word lacks odd parity");
	a_strobe_width_fixed: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$rose(strobe_o) |-> s_strobe_high ##1 !strobe_o)
		else $error("strobe high width wrong");
	a_idle_no_strobe: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		state_reg == dclh_pkg::ST_IDLE && $past(state_reg) == dclh_pkg::ST_IDLE |-> !strobe_o)
		else $error("strobe while idle");
	a_slip_no_strobe: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		state_reg == dclh_pkg::ST_DATA && cnt_reg == 4'h0 && !exec_s |=> !strobe_o)
		else $error("strobe during slip");
	a_busy_held_result: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$fell(busy_o) |-> $past(state_reg) == dclh_pkg::ST_RES && !ready_o)
		else $error("busy fell outside the result phase");
	a_result_word_stable: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		state_reg == dclh_pkg::ST_RES && strobe_o |-> $stable(xw_o) && !xw_oe_n_o)
		else $error("result word moved under its strobe");
	a_term_waits_select: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		state_reg == dclh_pkg::ST_TERM && sel_s |=> state_reg == dclh_pkg::ST_TERM && !ready_o)
		else $error("result started while select still high");
	a_sector_bound_count: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		state_reg == dclh_pkg::ST_DATA |-> words_reg < dclh_pkg::SECTOR_WORDS)
		else $error("sector word count overran");
	a_first_word_open: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		state_reg == dclh_pkg::ST_IDLE && sel_s && !sel_d_reg && send_s && !busy_o && !ready_o
		|=> state_reg == dclh_pkg::ST_W1 ##1 strobe_o)
		else $error("first word not strobed");
endmodule
`default_nettype wire

// File: dclh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dclh_host_model (
	// Clock.
	input  wire logic        mclk_i,
	// Link from the controller.
	input  wire logic        strobe_i,
	input  wire logic        ready_i,
	input  wire logic        busy_i,
	input  wire logic        oe_n_i,
	input  wire logic [15:0] line_i,
	input  wire logic        par_i,
	// Link toward the controller.
	output logic [15:0]      word_o,
	output logic             par_o,
	output logic             send_o,
	output logic             select_o
);
	logic [16:0] rx_q[$];
	logic [15:0] wq[$];
	int          par_errs = 0;
	int          ndata = 0;
	int          stop_at = 0;
	logic        stb_q = 1'b0;
	logic        wr = 1'b0;
	logic        seen = 1'b0;

	initial begin
		word_o = 16'h0000;
		par_o = 1'b1;
		send_o = 1'b0;
		select_o = 1'b0;
	end

	task automatic put(input logic [15:0] w);
		word_o = w;
		par_o = ~^w;
	endtask

	task automatic start(input logic [15:0] w1, input logic [15:0] w2, input logic is_wr);
		int n;
		wr = is_wr;
		ndata = 0;
		put(w1);
		send_o = 1'b1;
		repeat (3) @(posedge mclk_i);
		#2;
		select_o = 1'b1;
		for (n = 0; n < 200 && ready_i !== 1'b1; n++) @(posedge mclk_i);
		#2;
		put(w2);
		seen = 1'b1;
		for (n = 0; n < 200 && busy_i !== 1'b1; n++) @(posedge mclk_i);
		#2;
		if (wr && wq.size() > 0) put(wq.pop_front());
		else send_o = 1'b0;
	endtask

	always @(posedge mclk_i) begin
		stb_q <= strobe_i;
		if (strobe_i && !stb_q) begin
			if (busy_i && ready_i) ndata++;
			if (!oe_n_i) begin
				rx_q.push_back({ready_i, line_i});
				if (^{line_i, par_i} !== 1'b1) par_errs++;
			end
			if (wr && oe_n_i && busy_i && wq.size() > 0) begin
				#2;
				put(wq.pop_front());
			end
		end
	end

	always @(posedge mclk_i) begin
		if (select_o && seen && (!ready_i || (stop_at > 0 && ndata >= stop_at))) begin
			#2;
			select_o = 1'b0;
			send_o = 1'b0;
			seen = 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: test_dclh_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_dclh_ctrl;
	logic        mclk_i = 1'b0;
	logic        rstn_i, par, host_p, send, select, execute_i, xpar_o, xw_oe_n_o;
	logic        ready_o, busy_o, strobe_o, variant_o, cmd_valid_o, go_i, term_i;
	logic        seq_err_o, rd_valid_i, rd_ready_o, wr_valid_o, wr_ready_i, sector_done_o;
	logic [15:0] line, host_w, xw_o, rd_data_i, wr_data_o;
	logic [2:0]  op_code_o, spare_o, phase_o;
	logic [3:0]  unit_o;
	logic [18:0] file_addr_o;
	logic [12:0] status_i;
	logic [31:0] fire_ref_i, fire_code_o;
	logic [15:0] sup[$];
	logic [15:0] got[$];
	logic [15:0] dat[$];
	int          seed = 86;
	int          scnt = 0;
	int          err_count = 0;
	int          checked = 0;
	int          sdone = 0;

	always #50 mclk_i = ~mclk_i;

	assign line = xw_oe_n_o ? host_w : xw_o;
	assign par  = xw_oe_n_o ? host_p : xpar_o;

	dclh_ctrl i_dclh_ctrl (.mclk_i, .rstn_i, .xw_i(line), .xpar_i(par), .send_i(send),
		.select_i(select), .execute_i, .xw_o, .xpar_o, .xw_oe_n_o, .ready_o, .busy_o,
		.strobe_o, .op_code_o, .variant_o, .unit_o, .spare_o, .file_addr_o, .cmd_valid_o,
		.go_i, .term_i, .status_i, .fire_ref_i, .phase_o, .seq_err_o, .fire_code_o,
		.sector_done_o, .rd_data_i, .rd_valid_i, .rd_ready_o, .wr_data_o, .wr_valid_o,
		.wr_ready_i);

	dclh_host_model i_dclh_host_model (.mclk_i, .strobe_i(strobe_o), .ready_i(ready_o),
		.busy_i(busy_o), .oe_n_i(xw_oe_n_o), .line_i(line), .par_i(par), .word_o(host_w),
		.par_o(host_p), .send_o(send), .select_o(select));

	always @(posedge strobe_o) scnt++;
	always @(posedge sector_done_o) sdone++;

	always @(posedge mclk_i) begin
		if (rd_valid_i && rd_ready_o) void'(sup.pop_front());
		if (wr_valid_o && wr_ready_i) got.push_back(wr_data_o);
		#2;
		rd_valid_i = sup.size() > 0;
		rd_data_i = sup.size() > 0 ? sup[0] : 16'h0000;
		wr_ready_i = ($random(seed) & 3) != 0;
	end

	task automatic end_of_test();
		$display("Counts: %0d compared, %0d mismatched", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic step(inout int n);
		@(posedge mclk_i);
		#2;
		n++;
		if (n > 5000) begin
			err_count++;
			$display("ERROR %0t: wait ran out", $time);
			end_of_test();
		end
	endtask

	function automatic logic [31:0] crc(input logic [15:0] q[$]);
		logic [31:0] c;
		logic        fb;
		c = dclh_pkg::FIRE_INIT;
		foreach (q[i]) for (int b = 15; b >= 0; b--) begin
			fb = c[31] ^ q[i][b];
			c = {c[30:0], 1'b0} ^ (fb ? dclh_pkg::FIRE_POLY : 32'h0000_0000);
		end
		return c;
	endfunction

	task automatic run_op(input logic [2:0] op, input logic go, input logic trm);
		logic [15:0] w1, w2, res;
		logic [18:0] fa;
		logic [3:0]  unit;
		logic [2:0]  spare;
		logic [16:0] r;
		logic        wr, vbit;
		int          n, s;
		fa = 19'($random(seed));
		unit = 4'($random(seed));
		spare = 3'($random(seed));
		vbit = 1'($random(seed));
		wr = op == dclh_pkg::OP_WRITE;
		dat = {};
		for (n = 0; n < 90; n++) dat.push_back(16'($random(seed)));
		w1 = {fa[4:0], spare, unit, vbit, op};
		w2 = {2'b11, fa[18:5]};
		go_i = go;
		status_i = 13'($random(seed));
		fire_ref_i = crc(dat) ^ {31'h0, ~wr};
		got = {};
		sdone = 0;
		res = 16'h0000;
		i_dclh_host_model.rx_q = {};
		i_dclh_host_model.stop_at = 20;
		if (wr && go) i_dclh_host_model.wq = dat;
		fork
			i_dclh_host_model.start(w1, w2, wr);
		join_none
		for (n = 0; cmd_valid_o !== 1'b1; ) step(n);
		chk(op_code_o, op);
		chk(unit_o, unit);
		chk(spare_o, spare);
		chk(variant_o, vbit);
		chk(file_addr_o, fa);
		chk(ready_o, 1);
		if (go) begin
			for (n = 0; busy_o !== 1'b1; ) step(n);
			repeat (4) step(n);
			chk(phase_o, dclh_pkg::PH_DATA);
			if (!wr) begin
				sup = dat;
				for (n = 0; i_dclh_host_model.ndata < 2; ) step(n);
				execute_i = 1'b0;
				repeat (6) step(n);
				s = scnt;
				repeat (40) step(n);
				chk(scnt, s);
				chk(phase_o, dclh_pkg::PH_SLIP);
				chk(rd_ready_o, 0);
				execute_i = 1'b1;
			end
			// controller termination requested after the fifth word.
			if (trm) begin
				for (n = 0; i_dclh_host_model.ndata < 5; ) step(n);
				term_i = 1'b1;
				step(n);
				term_i = 1'b0;
			end
		end
		for (n = 0; busy_o !== 1'b0 || select !== 1'b0; ) step(n);
		repeat (3) step(n);
		chk(i_dclh_host_model.ndata, trm ? 5 : (go ? 90 : 0));
		chk(sdone, (go && !trm) ? 1 : 0);
		n = 0;
		s = 0;
		foreach (i_dclh_host_model.rx_q[i]) begin
			r = i_dclh_host_model.rx_q[i];
			if (r[16]) chk(r[15:0], dat[n++]);
			else begin
				res = r[15:0];
				s++;
			end
		end
		chk(s, 1);
		chk(res, {status_i, ~go | trm, 1'b0, go & ~wr & ~trm});
		if (go && !trm) chk(fire_code_o, crc(dat));
		if (wr && go) foreach (dat[i]) chk(got[i], dat[i]);
		chk(xw_oe_n_o, 1);
		chk(phase_o, dclh_pkg::PH_IDLE);
		chk(seq_err_o, 0);
		chk(i_dclh_host_model.par_errs, 0);
	endtask

	initial begin
		rstn_i = 1'b0;
		execute_i = 1'b1;
		go_i = 1'b1;
		term_i = 1'b0;
		status_i = 13'h0000;
		fire_ref_i = 32'h0000_0000;
		rd_valid_i = 1'b0;
		rd_data_i = 16'h0000;
		wr_ready_i = 1'b0;
		repeat (16) @(posedge mclk_i);
		#2;
		rstn_i = 1'b1;
		chk(xw_oe_n_o, 1);
		chk({ready_o, busy_o, strobe_o}, 0);
		run_op(dclh_pkg::OP_READ, 1'b1, 1'b0);
		run_op(dclh_pkg::OP_WRITE, 1'b1, 1'b0);
		run_op(dclh_pkg::OP_READ, 1'b0, 1'b0);
		run_op(dclh_pkg::OP_READ, 1'b1, 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
